// >>> verif/tcs_far_model.sv
`timescale 1ns/1ps
module tcs_far_model (
  input wire logic pclk, fetch_req, xfer_en,
  input wire logic [1:0] lag,
  output logic fetch_done, info_load, xfer_step, xfer_last,
  output logic [7:0] info_low, info_high
);
  // A count of one makes every step a reload of the counter.
  assign {info_low, info_high} = 16'h0101;
  // Each fetch or transfer is answered once, after lag idle cycles.
  initial begin
    {fetch_done, info_load, xfer_step, xfer_last} = 4'h0;
    forever begin
      @(posedge pclk);
      if (fetch_req || xfer_en) begin
        repeat (lag) @(posedge pclk);
        {fetch_done, info_load} <= {2{fetch_req}};
        {xfer_step, xfer_last} <= {2{!fetch_req}};
        @(posedge pclk);
        {fetch_done, info_load, xfer_step, xfer_last} <= 4'h0;
      end
    end
  end
endmodule

// >>> verif/tcs_top_properties.sv
`timescale 1ns/1ps
module tcs_top_properties #(parameter int VW = 8) (
  input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [VW-1:0] act_vector,
  input wire logic act_chain, act_ack, xfer_step, xfer_last, addr_err, nmi_pin,
  input wire logic fetch_req, xfer_en, chain_go
);
  logic skip_r, valid_r, chain_r;
  logic [VW-1:0] vec_r;
  wire ctl_acc = psel && penable && pready && paddr == 12'h000;
  // Shadow of the skip decision; any stop forgets the stored vector.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {skip_r, valid_r, chain_r, vec_r} <= '0;
    end else begin
      if (ctl_acc && pwrite) skip_r <= pwdata[4];
      if (act_ack) vec_r <= act_vector;
      // Only a chain that really happened forces the next fetch.
      if (chain_go) chain_r <= 1'b1;
      else if (act_ack) chain_r <= 1'b0;
      valid_r <= !(addr_err || nmi_pin) && (valid_r || act_ack);
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s; psel && !penable; endsequence
  sequence ctl_rd_s; ctl_acc && !pwrite; endsequence
  apb_ready_a: assert property (setup_s |=> pready) else $error("no ready");
  unmapped_err_a: assert property (pready && paddr > 12'h00C |-> pslverr) else $error("no err");
  rsvd_zero_a: assert property (ctl_rd_s |-> prdata[7:5] == 3'h0) else $error("rsvd");
  ro_zero_a: assert property (ctl_rd_s |-> prdata[2:1] == 2'h0) else $error("ro");
  fetch_choice_a: assert property (act_ack |-> fetch_req ==
    !(skip_r && valid_r && !chain_r && act_vector == vec_r)) else $error("fetch");
  one_path_a: assert property (act_ack |-> fetch_req != xfer_en) else $error("path");
  stop_halt_a: assert property (addr_err |-> ##[1:2] !(xfer_en || fetch_req)) else $error("halt");
  chain_cause_a: assert property (chain_go |-> $past(xfer_step && xfer_last)) else $error("chain");
endmodule
bind tcs_top tcs_top_properties #(.VW(VW)) u_props (.*);

// >>> verif/tcs_top_tb.sv
`timescale 1ns/1ps
module tcs_top_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pval = 0, pch;
  logic act_req = 0, act_chain = 0, act_repeat = 0, addr_err = 0, nmi_pin = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [7:0] act_vector = '0, info_low, info_high, ctl, pv;
  logic [1:0] lag = '0;
  logic pready, pslverr, act_ack, fetch_done, info_load, xfer_step, xfer_last;
  logic fetch_req, xfer_en, chain_go, irq, err;
  int n_mismatch = 0, checks = 0, n_chain = 0;
  tcs_top u_tcs_top (.*);
  tcs_far_model u_tcs_far_model (.*);
  initial forever #10 pclk = ~pclk;
  // Chain pulses last one cycle, so they are tallied as they pass.
  always @(posedge pclk) if (chain_go === 1'b1) n_chain <= n_chain + 1;
  task automatic cmp(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One idle edge after each transfer keeps two requests apart.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
    @(posedge pclk);
  endtask
  task automatic act(input logic [7:0] v, input logic ch, rp);
    int c0;
    logic f;
    c0 = n_chain;
    f = !(ctl[4] && pval && !pch && v == pv);
    {act_req, act_vector, act_chain, act_repeat, lag} <= {1'b1, v, ch, rp, 2'($urandom)};
    do @(posedge pclk); while (act_ack !== 1'b1);
    act_req <= 1'b0;
    cmp(fetch_req, f);
    do @(posedge pclk); while (fetch_req !== 1'b0 || xfer_en !== 1'b0);
    @(posedge pclk);
    cmp(n_chain - c0, ch && (!rp || ctl[3]));
    {pval, pv, pch} = {1'b1, v, ch && (!rp || ctl[3])};
  endtask
  // The flag must survive a write of one and a write without a read.
  task automatic stop_clear();
    repeat (6) @(posedge pclk);
    cmp(irq, 1'b1);
    apb(1'b0, 12'h000, 32'h0);
    cmp(rd, ctl | 8'h01);
    apb(1'b1, 12'h000, ctl | 8'h01);
    apb(1'b1, 12'h000, ctl);
    apb(1'b0, 12'h000, 32'h0);
    cmp(rd, ctl | 8'h01);
    apb(1'b1, 12'h000, ctl);
    apb(1'b0, 12'h000, 32'h0);
    cmp(rd, ctl);
    apb(1'b0, 12'h004, 32'h0);
    @(posedge pclk);
    cmp({rd[0], irq}, 2'h2);
    pval = 1'b0;
  endtask
  initial begin
    void'($urandom(1));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    cmp(rd, 32'h0);
    apb(1'b1, 12'h000, 32'hFF);
    apb(1'b0, 12'h000, 32'h0);
    cmp(rd, 32'h18);
    apb(1'b1, 12'h008, 32'h1);
    apb(1'b0, 12'h030, 32'h0);
    cmp(err, 1'b1);
    cmp(rd, 32'h0);
    for (int i = 0; i < 40; i++) begin
      ctl = {3'h0, 2'($urandom), 3'h0};
      apb(1'b1, 12'h000, ctl);
      act(8'($urandom % 2), 1'($urandom), 1'($urandom));
    end
    addr_err <= 1'b1;
    @(posedge pclk) addr_err <= 1'b0;
    stop_clear();
    nmi_pin <= 1'b1;
    repeat (2) @(posedge pclk);
    nmi_pin <= 1'b0;
    stop_clear();
    act(pv, 1'b0, 1'b0);
    wrap_up();
  end
  initial begin
    #100us;
    n_mismatch++;
    wrap_up();
  end
endmodule

// >>> verilog/tcs_params.svh
`ifndef TCS_PARAMS_SVH
`define TCS_PARAMS_SVH
// What this block does
// - Control bits 7 to 5 read zero.
// - Compare each vector with the previous one.
// - Skip fetch on match when skip enabled.
// - After chain activation always fetch everything.
// - Chain at repeat reload only if enabled.
// - Address error or NMI sets stop, halts.
// - Stop flag clears by read one, write zero.
// - Control bits 2 and 1 are read-only.
// - Repeat counter decrements, reloads from high half.
`define TCS_OFS_CTRL 12'h000
`define TCS_OFS_STAT 12'h004
`define TCS_OFS_MASK 12'h008
`define TCS_OFS_STATE 12'h00C
`define TCS_BIT_SKIP 4
`define TCS_BIT_CHAIN 3
`define TCS_BIT_STOP 0
`define TCS_CTRL_WMASK 8'h18
`define TCS_CTRL_RST 8'h00
`define TCS_EV_STOP 0
`define TCS_EV_DONE 1
`define TCS_EV_CHAIN 2
`define TCS_NEV 3
`endif

// >>> verilog/tcs_pkg.sv
package tcs_pkg;
  typedef enum logic [3:0] {
    TCS_IDLE  = 4'h1,
    TCS_FETCH = 4'h2,
    TCS_XFER  = 4'h4,
    TCS_HALT  = 4'h8
  } tcs_state_t;
endpackage

// >>> verilog/tcs_repeat_cnt.sv
`timescale 1ns/1ps
`include "tcs_params.svh"
module tcs_repeat_cnt #(
  parameter int W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [W-1:0] load_low,
  input wire logic [W-1:0] load_high,
  input wire logic step,
  output logic [W-1:0] count,
  output logic reload
);
  logic [W-1:0] low_r;
  logic [W-1:0] high_r;
  logic [W-1:0] dec;

  // Reload fires in the step taken while the low counter holds one.
  assign dec = low_r - {{(W-1){1'b0}}, 1'b1};
  assign reload = step && (dec == '0);
  assign count = low_r;

  // Counter and reload value; a fresh load wins over a step.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_r <= '0;
      high_r <= '0;
    end else if (load) begin
      low_r <= load_low;
      high_r <= load_high;
    end else if (step) begin
      low_r <= reload ? high_r : dec;
    end
  end
endmodule

// >>> verilog/tcs_top.sv
`timescale 1ns/1ps
`include "tcs_params.svh"
module tcs_top #(
  parameter int VW = 8,
  parameter int CW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic act_req,
  input wire logic [VW-1:0] act_vector,
  input wire logic act_chain,
  input wire logic act_repeat,
  output logic act_ack,
  input wire logic fetch_done,
  input wire logic info_load,
  input wire logic [CW-1:0] info_low,
  input wire logic [CW-1:0] info_high,
  input wire logic xfer_step,
  input wire logic xfer_last,
  input wire logic addr_err,
  input wire logic nmi_pin,
  output logic fetch_req,
  output logic xfer_en,
  output logic chain_go,
  output logic irq
);
  logic [7:0] ctrl_r;
  logic stop_r;
  logic stop_seen_r;
  logic [VW-1:0] prev_vec_r;
  logic prev_valid_r;
  logic prev_chain_r;
  logic [`TCS_NEV-1:0] stat_r;
  logic [`TCS_NEV-1:0] mask_r;
  logic [`TCS_NEV-1:0] ev;
  logic [2:0] nmi_sync_r;
  logic nmi_lvl_r;
  logic nmi_rise;
  logic stop_ev;
  logic wr;
  logic rd;
  logic ctrl_wr;
  logic [7:0] ctrl_view;
  logic skip;
  logic reload;
  logic [CW-1:0] low_count;
  tcs_pkg::tcs_state_t state_r;

  // The NMI pin is asynchronous; the edge is taken once stages two and three agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_sync_r <= 3'h0;
      nmi_lvl_r <= 1'b0;
    end else begin
      nmi_sync_r <= {nmi_sync_r[1:0], nmi_pin};
      if (nmi_sync_r[2] == nmi_sync_r[1]) begin
        nmi_lvl_r <= nmi_sync_r[2];
      end
    end
  end
  assign nmi_rise = (nmi_sync_r[2] == nmi_sync_r[1]) && nmi_sync_r[2] && !nmi_lvl_r;
  assign stop_ev = addr_err || nmi_rise;

  // APB decode; every access completes in its first access cycle.
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign ctrl_wr = wr && (paddr == `TCS_OFS_CTRL);
  assign ctrl_view = {3'h0, ctrl_r[4:3], 2'h0, stop_r};

  // Only the enable bits are writable; reserved and read-only bits stay zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `TCS_CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_r <= pwdata[7:0] & `TCS_CTRL_WMASK;
    end
  end

  // Stop flag: set wins over clear, and a clear needs a prior read of one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_r <= 1'b0;
      stop_seen_r <= 1'b0;
    end else begin
      if (stop_ev) begin
        stop_r <= 1'b1;
      end else if (ctrl_wr && stop_seen_r && !pwdata[`TCS_BIT_STOP]) begin
        stop_r <= 1'b0;
      end
      if (stop_ev || ctrl_wr) begin
        stop_seen_r <= 1'b0;
      end else if (rd && paddr == `TCS_OFS_CTRL && stop_r) begin
        stop_seen_r <= 1'b1;
      end
    end
  end

  // Skip decision is combinational on the incoming vector.
  assign skip = ctrl_r[`TCS_BIT_SKIP] && prev_valid_r && !prev_chain_r
    && (act_vector == prev_vec_r);

  tcs_repeat_cnt #(
    .W(CW)
  ) u_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .load(info_load),
    .load_low(info_low),
    .load_high(info_high),
    .step(xfer_step && (state_r == tcs_pkg::TCS_XFER) && act_repeat),
    .count(low_count),
    .reload(reload)
  );

  // Activation sequencer; a stop event overrides every state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= tcs_pkg::TCS_IDLE;
      act_ack <= 1'b0;
      fetch_req <= 1'b0;
      xfer_en <= 1'b0;
      chain_go <= 1'b0;
    end else begin
      act_ack <= 1'b0;
      chain_go <= 1'b0;
      if (stop_ev) begin
        state_r <= tcs_pkg::TCS_HALT;
        fetch_req <= 1'b0;
        xfer_en <= 1'b0;
      end else begin
        unique case (state_r)
          tcs_pkg::TCS_IDLE: begin
            if (act_req) begin
              act_ack <= 1'b1;
              if (skip) begin
                state_r <= tcs_pkg::TCS_XFER;
                xfer_en <= 1'b1;
              end else begin
                state_r <= tcs_pkg::TCS_FETCH;
                fetch_req <= 1'b1;
              end
            end
          end
          tcs_pkg::TCS_FETCH: begin
            if (fetch_done) begin
              state_r <= tcs_pkg::TCS_XFER;
              fetch_req <= 1'b0;
              xfer_en <= 1'b1;
            end
          end
          tcs_pkg::TCS_XFER: begin
            if (xfer_step && xfer_last) begin
              state_r <= tcs_pkg::TCS_IDLE;
              xfer_en <= 1'b0;
              // Repeat mode chains at reload only when enabled.
              chain_go <= act_chain && (!act_repeat
                || (reload && ctrl_r[`TCS_BIT_CHAIN]));
            end
          end
          tcs_pkg::TCS_HALT: begin
            if (!stop_r) begin
              state_r <= tcs_pkg::TCS_IDLE;
            end
          end
        endcase
      end
    end
  end

  // Previous vector memory; chain outcome forces a refetch next time.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_vec_r <= '0;
      prev_valid_r <= 1'b0;
      prev_chain_r <= 1'b0;
    end else if (stop_ev) begin
      prev_valid_r <= 1'b0;
    end else begin
      if (state_r == tcs_pkg::TCS_IDLE && act_req) begin
        prev_vec_r <= act_vector;
        prev_valid_r <= 1'b1;
      end
      if (state_r == tcs_pkg::TCS_XFER && xfer_step && xfer_last) begin
        prev_chain_r <= act_chain && (!act_repeat || (reload && ctrl_r[`TCS_BIT_CHAIN]));
      end
    end
  end

  // Sticky event bits; set wins over the clear that a status read performs.
  assign ev = {chain_go, (state_r == tcs_pkg::TCS_XFER) && xfer_step && xfer_last, stop_ev};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= '0;
      mask_r <= '0;
      irq <= 1'b0;
    end else begin
      // The clear falls on the setup edge, where prdata takes its snapshot, so no event is lost.
      if (psel && !penable && !pwrite && paddr == `TCS_OFS_STAT) begin
        stat_r <= ev;
      end else begin
        stat_r <= stat_r | ev;
      end
      if (wr && paddr == `TCS_OFS_MASK) begin
        mask_r <= pwdata[`TCS_NEV-1:0];
      end
      irq <= |(stat_r & mask_r);
    end
  end

  // Read mux is registered so prdata comes from a flip-flop; answer in first access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(paddr == `TCS_OFS_CTRL || paddr == `TCS_OFS_STAT
        || paddr == `TCS_OFS_MASK || paddr == `TCS_OFS_STATE);
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `TCS_OFS_CTRL: prdata <= {24'h00_0000, ctrl_view};
          `TCS_OFS_STAT: prdata <= {29'h0000_0000, stat_r};
          `TCS_OFS_MASK: prdata <= {29'h0000_0000, mask_r};
          `TCS_OFS_STATE: prdata <= {{(24-CW){1'b0}}, low_count, 4'h0, state_r};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule
